// file: bench/swc_master_clear_n_source.sv
`timescale 1ns/1ps
`default_nettype none
// The pin has a pull-up, so released means high.
module swc_clear_source (
   input wire logic clk,
   input wire logic pulse_req,
   input wire logic [7:0] pulse_len,
   output var logic master_clear_n
);
   logic [7:0] left_r = 8'h00;
   initial master_clear_n = 1'b1;
   always @(posedge clk) begin
      if (pulse_req && left_r == 8'h00) begin
         master_clear_n <= 1'b0;
         left_r <= pulse_len;
      end else if (left_r > 8'h01) left_r <= left_r - 8'h01;
      else if (left_r == 8'h01) begin
         left_r <= 8'h00;
         master_clear_n <= 1'b1;
      end
   end
endmodule : swc_clear_source
`default_nettype wire

// file: bench/swc_sleep_wake_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module swc_sleep_wake_monitor #(
   parameter int unsigned RESET_DELAY_CYC = 20
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic master_clear_n,
   input wire logic watchdog_enable_fuse,
   input wire logic sleep_exec,
   input wire swc_pkg::swc_io_t pin_io,
   input wire swc_pkg::swc_flags_t flags,
   input wire logic [7:0] status_flag_bits,
   input wire logic core_reset_n,
   input wire logic osc_drive_en,
   input wire logic sleeping,
   input wire logic watchdog_timeout
);
   import swc_pkg::*;
   int unsigned low_cnt_r;
   // The hold cycle after a master clear counts too, hence the one-cycle slack below.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn || core_reset_n || !master_clear_n) low_cnt_r <= 0;
      else low_cnt_r <= low_cnt_r + 1;
   end
   ////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_sleep_entry: assert property (
      sleep_exec && core_reset_n && !sleeping && master_clear_n
      |=> watchdog_timeout || (sleeping && status_flag_bits == 8'h10)) else $error("sleep entry");
   a_osc_off: assert property (
      osc_drive_en == !sleeping) else $error("oscillator drive");
   a_pins_frozen: assert property (
      sleeping && $past(sleeping) |-> $stable(pin_io)) else $error("pins moved");
   a_clear_wake: assert property (
      !master_clear_n |=> !core_reset_n && !sleeping) else $error("master clear wake");
   a_wake_cause: assert property (
      $fell(sleeping) |-> !core_reset_n && (watchdog_timeout || !$past(master_clear_n)))
      else $error("bad wake");
   a_fuse_off: assert property (
      !watchdog_enable_fuse && !$past(watchdog_enable_fuse) |-> !watchdog_timeout)
      else $error("disabled watchdog fired");
   a_timeout_flag: assert property (
      watchdog_timeout |-> !flags.timeout_flag_n && !core_reset_n
      && flags.powerdown_flag_n == $past(flags.powerdown_flag_n)) else $error("timeout flags");
   a_delay_len: assert property (
      $rose(core_reset_n) |-> low_cnt_r >= RESET_DELAY_CYC && low_cnt_r <= RESET_DELAY_CYC + 1)
      else $error("reset delay length");
   c_sleep: cover property (sleep_exec ##1 sleeping);
   c_wdt_wake: cover property (sleeping ##1 watchdog_timeout);
   c_clear_wake: cover property ($fell(sleeping) && !watchdog_timeout);
endmodule : swc_sleep_wake_monitor
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import swc_pkg::*;
   logic clk = 0, resetn = 0, fuse = 0, sleep_exec = 0, clrwdt_exec = 0, mreq = 0;
   logic [7:0] status;
   logic ext_clear_n, core_reset_n, osc_drive_en, sleeping, wdt_to;
   swc_wdt_cfg_t cfg = '{1'b1, 3'h1};
   swc_io_t core_io = '{12'ha5c, 12'h0f3};
   swc_io_t pin_io, frozen;
   swc_flags_t flags;
   int errors = 0, num_checks = 0, n;
   always #2 clk = ~clk;
   swc_clear_source swc_clear_source_inst (.clk(clk), .pulse_req(mreq), .pulse_len(8'h03),
      .master_clear_n(ext_clear_n));
   swc_sleep_wake_control #(.RESET_DELAY_CYC(20), .WDT_PERIOD_CYC(10))
      swc_sleep_wake_control_inst (
      .clk(clk), .resetn(resetn), .master_clear_n(ext_clear_n), .watchdog_enable_fuse(fuse),
      .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec), .wdt_cfg(cfg), .core_io(core_io),
      .pin_io(pin_io), .flags(flags), .status_flag_bits(status), .core_reset_n(core_reset_n),
      .osc_drive_en(osc_drive_en), .sleeping(sleeping), .watchdog_timeout(wdt_to));
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      if (errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   task automatic wait_for(input logic want_run);
      n = 0;
      while ((want_run ? core_reset_n : wdt_to) !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      // A wait that runs out is a failure, not a silent fall-through.
      check(want_run ? core_reset_n : wdt_to, 1);
   endtask : wait_for
   task automatic do_sleep;
      frozen = core_io;
      sleep_exec = 1;
      cyc(1);
      sleep_exec = 0;
      core_io = ~core_io;
      check(sleeping, 1);
      check(osc_drive_en, 0);
      check(status, 8'h10);
      check(flags, 2'b10);
      cyc(1);
      check(pin_io, frozen);
   endtask : do_sleep
   task automatic t_master_clear_n_wake;
      do_sleep();
      cyc(200);
      check(sleeping, 1);
      mreq = 1;
      cyc(1);
      mreq = 0;
      cyc(1);
      check(core_reset_n, 0);
      check(sleeping, 0);
      check(osc_drive_en, 1);
      check(status, 8'h10);
      wait_for(1);
      check(status, 8'h10);
   endtask : t_master_clear_n_wake
   // Watchdog period here is 10 cycles times a postscaler ratio of 2.
   task automatic t_wdt_wake;
      fuse = 1;
      cyc(15);
      clrwdt_exec = 1;
      cyc(1);
      clrwdt_exec = 0;
      check(status, 8'h18);
      cyc(15);
      do_sleep();
      wait_for(0);
      check(n >= 17 && n <= 20, 1);
      check(status, 8'h00);
      check(flags, 2'b00);
      check(core_reset_n, 0);
      check(ext_clear_n, 1);
      wait_for(1);
      wait_for(0);
      check(n >= 18 && n <= 22, 1);
      fuse = 0;
      wait_for(1);
      check(status, 8'h00);
   endtask : t_wdt_wake
   initial begin
      cyc(2);
      check(status, 8'h18);
      resetn = 1;
      wait_for(1);
      check(pin_io, core_io);
      t_master_clear_n_wake();
      t_wdt_wake();
      // The timeout flag is low here, so this sleep shows that entry sets it.
      t_master_clear_n_wake();
      end_of_test();
   end
   initial begin
      cyc(4000);
      errors++;
      end_of_test();
   end
endmodule : tb
bind swc_sleep_wake_control swc_sleep_wake_monitor #(.RESET_DELAY_CYC(RESET_DELAY_CYC))
   swc_sleep_wake_monitor_inst (.clk(clk), .resetn(resetn), .master_clear_n(master_clear_n),
   .watchdog_enable_fuse(watchdog_enable_fuse), .sleep_exec(sleep_exec), .pin_io(pin_io),
   .flags(flags), .status_flag_bits(status_flag_bits), .core_reset_n(core_reset_n),
   .osc_drive_en(osc_drive_en), .sleeping(sleeping), .watchdog_timeout(watchdog_timeout));
`default_nettype wire

// file: logic/swc_consts.svh
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH

// Clock period of the always-on control clock.
`define SWC_CLK_PERIOD_NS 4
// Device reset delay and watchdog base period, nominal.
`define SWC_RESET_DELAY_MS 18
`define SWC_WDT_PERIOD_MS 18
// Least time: round up to whole cycles.
`define SWC_RESET_DELAY_CYC \
   ((`SWC_RESET_DELAY_MS * 1000000 + `SWC_CLK_PERIOD_NS - 1) / `SWC_CLK_PERIOD_NS)
// Nominal period: round down to whole cycles.
`define SWC_WDT_PERIOD_CYC ((`SWC_WDT_PERIOD_MS * 1000000) / `SWC_CLK_PERIOD_NS)
// Status register bit positions of the two flags.
`define SWC_STATUS_TO_BIT 4
`define SWC_STATUS_PD_BIT 3
// Width of the status byte and of the I/O port group.
`define SWC_STATUS_W 8
`define SWC_IO_W 12
// Postscaler select width and the postscaler counter width.
`define SWC_PS_SEL_W 3
`define SWC_PS_CNT_W 8
// Flag values after power-up.
`define SWC_TO_POR 1'b1
`define SWC_PD_POR 1'b1

`endif

// file: logic/swc_pkg.sv
`include "swc_consts.svh"

package swc_pkg;

   typedef enum logic [1:0] {
      SWC_RUN,
      SWC_SLEEP,
      SWC_HOLD,
      SWC_DELAY
   } swc_state_t;

   typedef struct packed {
      logic prescale_to_wdt;
      logic [`SWC_PS_SEL_W-1:0] prescale_sel;
   } swc_wdt_cfg_t;

   typedef struct packed {
      logic [`SWC_IO_W-1:0] drive;
      logic [`SWC_IO_W-1:0] oe;
   } swc_io_t;

   typedef struct packed {
      logic timeout_flag_n;
      logic powerdown_flag_n;
   } swc_flags_t;

endpackage : swc_pkg

// file: logic/swc_sleep_wake_control.sv
// How it works
// - Executing the sleep instruction puts the device into power-down.
// - Entering power-down clears the enabled watchdog and its postscaler and keeps it running.
// - Entering power-down sets the active-low timeout flag, status bit 4.
// - Entering power-down clears the active-low power-down flag, status bit 3.
// - Entering power-down turns off the oscillator driver so the core clock stops.
// - While powered down every I/O pin keeps its prior high, low or high-impedance state.
// - A watchdog time-out resets the device internally and never drives master clear low.
// - Only a master-clear reset or an enabled watchdog time-out ends power-down.
// - Either wake-up event gives a full device reset instead of resuming after the sleep.
// - A watchdog time-out wake-up clears the timeout flag to show its cause.
// - The power-down flag is set at power-up and cleared only by a sleep instruction.
// - Any wake-up from power-down clears the watchdog count.
// - A watchdog time-out starts the 18 ms reset delay, with the core held in reset meanwhile.
// - After a master-clear wake-up the timeout flag reads 1 and the power-down flag 0.
// - With the enable fuse at 0 the watchdog is off for good and can never wake the device.
`timescale 1ns/1ps
`default_nettype none
`include "swc_consts.svh"

module swc_sleep_wake_control #(
   parameter int unsigned RESET_DELAY_CYC = `SWC_RESET_DELAY_CYC,
   parameter int unsigned WDT_PERIOD_CYC = `SWC_WDT_PERIOD_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic master_clear_n,
   input wire logic watchdog_enable_fuse,
   input wire logic sleep_exec,
   input wire logic clrwdt_exec,
   input wire swc_pkg::swc_wdt_cfg_t wdt_cfg,
   input wire swc_pkg::swc_io_t core_io,
   output swc_pkg::swc_io_t pin_io,
   output swc_pkg::swc_flags_t flags,
   output logic [`SWC_STATUS_W-1:0] status_flag_bits,
   output logic core_reset_n,
   output logic osc_drive_en,
   output logic sleeping,
   output logic watchdog_timeout
);
   import swc_pkg::*;

   localparam int unsigned DLY_W = $clog2(RESET_DELAY_CYC + 1);
   localparam int unsigned WDT_W = $clog2(WDT_PERIOD_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.

   generate
      if (RESET_DELAY_CYC < 1) begin : g_bad_drt
         $error("RESET_DELAY_CYC must be at least one cycle");
      end
      if (WDT_PERIOD_CYC < 2) begin : g_bad_wdt
         $error("WDT_PERIOD_CYC must be at least two cycles");
      end
      if (`SWC_STATUS_TO_BIT >= `SWC_STATUS_W ||
          `SWC_STATUS_PD_BIT >= `SWC_STATUS_W) begin : g_bad_bit
         $error("status flag positions must lie inside the status byte");
      end
      if (((1 << `SWC_PS_SEL_W) - 1) > `SWC_PS_CNT_W) begin : g_bad_post
         $error("postscaler counter too narrow for the largest ratio");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // State and storage.

   swc_state_t state_r;
   swc_state_t state_nxt;
   logic [DLY_W-1:0] dly_cnt_r;
   logic [DLY_W-1:0] dly_cnt_nxt;
   logic [WDT_W-1:0] wdt_base_r;
   logic [WDT_W-1:0] wdt_base_nxt;
   logic [`SWC_PS_CNT_W-1:0] wdt_post_r;
   logic [`SWC_PS_CNT_W-1:0] wdt_post_nxt;
   logic to_n_r;
   logic to_n_nxt;
   logic pd_n_r;
   logic pd_n_nxt;
   swc_io_t frozen_io_r;
   logic tmo_r;

   ////////////////////////////////////////////////////////////////////////////
   // Decode of events.

   wire logic in_run = (state_r == SWC_RUN);
   wire logic in_sleep = (state_r == SWC_SLEEP);
   wire logic in_hold = (state_r == SWC_HOLD);
   wire logic in_delay = (state_r == SWC_DELAY);
   wire logic clear_pin_low = ~master_clear_n;
   // The sleep and clear-watchdog strobes only mean something while the core runs.
   wire logic sleep_go = in_run & sleep_exec & ~clear_pin_low;
   wire logic clrwdt_go = in_run & clrwdt_exec & ~clear_pin_low;
   // The watchdog counts in run and in sleep, and only when the fuse allows it.
   wire logic wdt_active = watchdog_enable_fuse & (in_run | in_sleep);
   wire logic base_wrap = (wdt_base_r == WDT_W'(WDT_PERIOD_CYC - 1));
   wire logic [`SWC_PS_CNT_W-1:0] post_limit =
      wdt_cfg.prescale_to_wdt ?
      ((`SWC_PS_CNT_W'(1) << wdt_cfg.prescale_sel) - `SWC_PS_CNT_W'(1)) :
      `SWC_PS_CNT_W'(0);
   wire logic post_wrap = (wdt_post_r >= post_limit);
   // A time-out loses to master clear, which takes the core into reset through the hold state on the same edge.
   wire logic wdt_fire = wdt_active & base_wrap & post_wrap & ~clear_pin_low;
   // Any sleep entry, clear-watchdog, wake-up or reset phase empties the watchdog chain.
   wire logic wdt_clear = sleep_go | clrwdt_go | ~wdt_active | wdt_fire;
   wire logic dly_done = (dly_cnt_r == DLY_W'(RESET_DELAY_CYC - 1));

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   always_comb begin
      state_nxt = state_r;
      dly_cnt_nxt = dly_cnt_r;
      case (state_r)
         SWC_RUN: begin
            if (clear_pin_low) begin
               state_nxt = SWC_HOLD;
            end else if (wdt_fire) begin
               state_nxt = SWC_DELAY;
               dly_cnt_nxt = '0;
            end else if (sleep_go) begin
               state_nxt = SWC_SLEEP;
            end
         end
         SWC_SLEEP: begin
            // Only these two events leave sleep, and both go through a full reset.
            if (clear_pin_low) begin
               state_nxt = SWC_HOLD;
            end else if (wdt_fire) begin
               state_nxt = SWC_DELAY;
               dly_cnt_nxt = '0;
            end
         end
         SWC_HOLD: begin
            // The delay restarts on every release, so a bouncing pin cannot shorten it.
            dly_cnt_nxt = '0;
            if (!clear_pin_low) begin
               state_nxt = SWC_DELAY;
            end
         end
         SWC_DELAY: begin
            if (clear_pin_low) begin
               state_nxt = SWC_HOLD;
            end else if (dly_done) begin
               state_nxt = SWC_RUN;
            end else begin
               dly_cnt_nxt = dly_cnt_r + DLY_W'(1);
            end
         end
         default: begin
            state_nxt = SWC_HOLD;
            dly_cnt_nxt = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog chain: base period divider, then the optional postscaler.

   always_comb begin
      wdt_base_nxt = wdt_base_r;
      wdt_post_nxt = wdt_post_r;
      if (wdt_clear) begin
         wdt_base_nxt = '0;
         wdt_post_nxt = '0;
      end else if (base_wrap) begin
         wdt_base_nxt = '0;
         wdt_post_nxt = wdt_post_r + `SWC_PS_CNT_W'(1);
      end else begin
         wdt_base_nxt = wdt_base_r + WDT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags.

   // The time-out is a hardware event and wins over a clear-watchdog in the same
   // cycle; master clear leaves both flags alone.
   always_comb begin
      to_n_nxt = to_n_r;
      pd_n_nxt = pd_n_r;
      if (wdt_fire) begin
         to_n_nxt = 1'b0;
      end else if (sleep_go) begin
         to_n_nxt = 1'b1;
         pd_n_nxt = 1'b0;
      end else if (clrwdt_go) begin
         to_n_nxt = 1'b1;
         pd_n_nxt = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // The asynchronous reset is power-up: it sets both flags and arms the delay.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= SWC_DELAY;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dly_cnt_r <= '0;
      end else begin
         dly_cnt_r <= dly_cnt_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdt_base_r <= '0;
      end else begin
         wdt_base_r <= wdt_base_nxt;
      end
   end

   // The postscaler only advances on a base wrap, so it counts whole base periods.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdt_post_r <= '0;
      end else begin
         wdt_post_r <= wdt_post_nxt;
      end
   end

   // The time-out pulse is registered so that it lines up with the entry into the delay.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tmo_r <= 1'b0;
      end else begin
         tmo_r <= wdt_fire;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         to_n_r <= `SWC_TO_POR;
      end else begin
         to_n_r <= to_n_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pd_n_r <= `SWC_PD_POR;
      end else begin
         pd_n_r <= pd_n_nxt;
      end
   end

   // Pin states are caught on the sleep strobe, from the last values the core drove.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frozen_io_r <= '0;
      end else if (sleep_go) begin
         frozen_io_r <= core_io;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin selection, one entry per I/O bit.

   // While the core is in reset its port drivers float; in sleep the caught
   // levels and enables stand, so a floating pin stays floating.
   genvar gi;
   generate
      for (gi = 0; gi < `SWC_IO_W; gi++) begin : g_pin
         wire logic use_frozen = in_sleep;
         wire logic in_reset = in_hold | in_delay;
         assign pin_io.drive[gi] = use_frozen ? frozen_io_r.drive[gi] :
                                   (in_reset ? 1'b0 : core_io.drive[gi]);
         assign pin_io.oe[gi] = use_frozen ? frozen_io_r.oe[gi] :
                                (in_reset ? 1'b0 : core_io.oe[gi]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // The master-clear pin is only ever an input here, so a watchdog reset stays
   // inside the core reset line.
   assign core_reset_n = in_run | in_sleep;
   assign osc_drive_en = ~in_sleep;
   assign sleeping = in_sleep;
   assign watchdog_timeout = tmo_r;
   assign flags.timeout_flag_n = to_n_r;
   assign flags.powerdown_flag_n = pd_n_r;

   always_comb begin
      status_flag_bits = '0;
      status_flag_bits[`SWC_STATUS_TO_BIT] = to_n_r;
      status_flag_bits[`SWC_STATUS_PD_BIT] = pd_n_r;
   end

endmodule : swc_sleep_wake_control

`default_nettype wire
